// File: logic/cclk_pkg.sv
// shared constants for the calendar clock counters
`default_nettype none
package cclk_pkg;
  // register offsets
  localparam logic [3:0] ADDR_SEC   = 4'h0;
  localparam logic [3:0] ADDR_MIN   = 4'h1;
  localparam logic [3:0] ADDR_HOUR  = 4'h2;
  localparam logic [3:0] ADDR_WEEK  = 4'h3;
  localparam logic [3:0] ADDR_DATE  = 4'h4;
  localparam logic [3:0] ADDR_MONTH = 4'h5;
  localparam logic [3:0] ADDR_YEAR  = 4'h6;
  localparam logic [3:0] ADDR_RAM   = 4'h7;
  localparam logic [3:0] ADDR_EXT   = 4'hd;
  // implemented-bit masks, unimplemented bits read zero
  localparam logic [7:0] MASK_SEC   = 8'h7f;
  localparam logic [7:0] MASK_MIN   = 8'h7f;
  localparam logic [7:0] MASK_HOUR  = 8'h3f;
  localparam logic [7:0] MASK_WEEK  = 8'h7f;
  localparam logic [7:0] MASK_DATE  = 8'h3f;
  localparam logic [7:0] MASK_MONTH = 8'h1f;
  localparam logic [7:0] MASK_EXT   = 8'hf3;
  // extension register fields
  localparam int EXT_TEST  = 7;
  localparam int EXT_ALARM = 6;
  localparam int EXT_UPD   = 5;
  localparam int EXT_RUN   = 4;
  localparam int EXT_SRC_H = 1;
  localparam int EXT_SRC_L = 0;
  // bcd ranges
  localparam logic [7:0] BCD_ZERO   = 8'h00;
  localparam logic [7:0] BCD_ONE    = 8'h01;
  localparam logic [7:0] BCD_MAX_MS = 8'h59;
  localparam logic [7:0] BCD_MAX_HR = 8'h23;
  localparam logic [7:0] BCD_MAX_MO = 8'h12;
  localparam logic [7:0] BCD_MAX_YR = 8'h99;
  localparam logic [7:0] BCD_D31    = 8'h31;
  localparam logic [7:0] BCD_D30    = 8'h30;
  localparam logic [7:0] BCD_D29    = 8'h29;
  localparam logic [7:0] BCD_D28    = 8'h28;
  localparam logic [7:0] BCD_FEB    = 8'h02;
  localparam logic [3:0] BCD_NINE   = 4'h9;
  // weekday one-hot ends
  localparam logic [6:0] WEEK_FIRST = 7'h01;
  localparam logic [6:0] WEEK_LAST  = 7'h40;
  // reset contents of the time registers
  localparam logic [7:0] RST_TIME   = 8'h00;
  localparam logic [7:0] RST_DAY    = 8'h01;
  localparam logic [7:0] RST_YEAR   = 8'h01;
  localparam logic [7:0] RST_EXT    = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SRC_FAST_HZ   = 4096;
  localparam int NS_PER_S      = 1_000_000_000;
  localparam logic [5:0] DIV_LAST = 6'h3f;
  // timer source codes
  typedef enum logic [1:0] {
    CCLK_SRC_4096 = 2'h0,
    CCLK_SRC_64   = 2'h1,
    CCLK_SRC_SEC  = 2'h2,
    CCLK_SRC_MIN  = 2'h3
  } cclk_src_t;

  // leap year when the bcd year is a multiple of four
  function automatic logic cclk_is_leap(input logic [7:0] yr);
    logic ones_even;
    ones_even = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
    cclk_is_leap = yr[4] ? ((yr[3:0] == 4'h2) || (yr[3:0] == 4'h6)) : ones_even;
  endfunction : cclk_is_leap

  // last date of a bcd month
  function automatic logic [7:0] cclk_last_date(input logic [7:0] mo, input logic [7:0] yr);
    case (mo)
      8'h04, 8'h06, 8'h09, 8'h11: cclk_last_date = BCD_D30;
      BCD_FEB: cclk_last_date = cclk_is_leap(yr) ? BCD_D29 : BCD_D28;
      default: cclk_last_date = BCD_D31;
    endcase
  endfunction : cclk_last_date
endpackage : cclk_pkg
`default_nettype wire

// File: logic/cclk_bcd_step.sv
// two-digit bcd incrementer with wrap from a top value to a bottom value
`timescale 1ns/1ps
`default_nettype none
module cclk_bcd_step
  import cclk_pkg::*;
(
  // count and range
  input  wire logic [7:0] cur,
  input  wire logic [7:0] bottom,
  input  wire logic [7:0] top,
  // result
  output logic      [7:0] nxt,
  output logic            at_top
);
  // digit carry when the low digit is nine
  assign at_top = (cur == top);
  assign nxt    = at_top ? bottom
                : (cur[3:0] == BCD_NINE) ? {4'(cur[7:4] + 4'h1), 4'h0}
                : {cur[7:4], 4'(cur[3:0] + 4'h1)};
endmodule : cclk_bcd_step
`default_nettype wire

// File: logic/cclk_core.sv
// calendar clock counters with register port and timer source selection
`timescale 1ns/1ps
`default_nettype none
module cclk_core
  import cclk_pkg::*;
#(
  parameter int FAST_DIV = NS_PER_S / (CLK_PERIOD_NS * SRC_FAST_HZ)
)
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // bus and control events
  input  wire logic       bus_release,
  input  wire logic       halt_count,
  // configuration seen by the timer and alarm logic
  output logic            alarm_target_select,
  output logic            update_period_select,
  output logic            timer_run,
  output logic            timer_source_sel_low,
  output logic            timer_source_sel_high,
  output logic      [7:0] alarm_compare_value,
  // event pulses
  output logic            timer_start,
  output logic            timer_tick,
  output logic            update_event
);
  localparam int PRE_W = $clog2(FAST_DIV);

  logic [PRE_W-1:0] pre_cnt;
  logic [5:0]       div64_cnt;
  logic [5:0]       div1_cnt;
  logic [7:0]       sixty_tick_count;
  logic [7:0]       minutes_count;
  logic [7:0]       hours_count;
  logic [6:0]       weekday_onehot;
  logic [7:0]       date_of_month;
  logic [7:0]       month_count;
  logic [7:0]       year_count;
  logic [7:0]       scratch_byte;
  logic [7:0]       extension_config;

  // prescaler ticks, 4096 Hz keeps running while halted
  wire fast_tick = (pre_cnt == PRE_W'(FAST_DIV - 1));
  wire hz64_tick = fast_tick && (div64_cnt == DIV_LAST) && !halt_count;
  wire sec_tick  = hz64_tick && (div1_cnt == DIV_LAST);

  // register write decode
  wire wr_sec   = reg_wr && (reg_addr == ADDR_SEC);
  wire wr_min   = reg_wr && (reg_addr == ADDR_MIN);
  wire wr_hour  = reg_wr && (reg_addr == ADDR_HOUR);
  wire wr_week  = reg_wr && (reg_addr == ADDR_WEEK);
  wire wr_date  = reg_wr && (reg_addr == ADDR_DATE);
  wire wr_month = reg_wr && (reg_addr == ADDR_MONTH);
  wire wr_year  = reg_wr && (reg_addr == ADDR_YEAR);
  wire wr_ram   = reg_wr && (reg_addr == ADDR_RAM);
  wire wr_ext   = reg_wr && (reg_addr == ADDR_EXT);

  // fast prescaler
  always_ff @(posedge clk)
  begin
    if (!rstn || fast_tick)
      pre_cnt <= '0;
    else
      pre_cnt <= PRE_W'(pre_cnt + 1'b1);
  end

  // sub-second dividers held clear while halted
  // divider freeze
  always_ff @(posedge clk)
  begin
    if (!rstn || halt_count)
      div64_cnt <= 6'h00;
    else if (fast_tick)
      div64_cnt <= 6'(div64_cnt + 6'h01);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn || halt_count)
      div1_cnt <= 6'h00;
    else if (hz64_tick)
      div1_cnt <= 6'(div1_cnt + 6'h01);
  end

  // bcd step results and rollover flags
  logic [7:0] sec_next, min_next, hour_next, date_next, month_next, year_next;
  logic       sec_top, min_top, hour_top, date_top, month_top, year_top;
  wire  [7:0] date_limit = cclk_last_date(month_count, year_count);

  wire sec_step   = sec_tick;
  wire min_step   = sec_step && sec_top;
  wire hour_step  = min_step && min_top;
  wire day_step   = hour_step && hour_top;
  wire month_step = day_step && date_top;
  wire year_step  = month_step && month_top;

  cclk_bcd_step u_sec (
    .cur    (sixty_tick_count),
    .bottom (BCD_ZERO),
    .top    (BCD_MAX_MS),
    .nxt    (sec_next),
    .at_top (sec_top)
  );

  cclk_bcd_step u_min (
    .cur    (minutes_count),
    .bottom (BCD_ZERO),
    .top    (BCD_MAX_MS),
    .nxt    (min_next),
    .at_top (min_top)
  );

  cclk_bcd_step u_hour (
    .cur    (hours_count),
    .bottom (BCD_ZERO),
    .top    (BCD_MAX_HR),
    .nxt    (hour_next),
    .at_top (hour_top)
  );

  cclk_bcd_step u_date (
    .cur    (date_of_month),
    .bottom (BCD_ONE),
    .top    (date_limit),
    .nxt    (date_next),
    .at_top (date_top)
  );

  cclk_bcd_step u_month (
    .cur    (month_count),
    .bottom (BCD_ONE),
    .top    (BCD_MAX_MO),
    .nxt    (month_next),
    .at_top (month_top)
  );

  cclk_bcd_step u_year (
    .cur    (year_count),
    .bottom (BCD_ZERO),
    .top    (BCD_MAX_YR),
    .nxt    (year_next),
    .at_top (year_top)
  );

  // time counters: a host write wins over a tick in the same cycle
  // packed bcd storage
  always_ff @(posedge clk)
  begin
    if (!rstn)
      sixty_tick_count <= RST_TIME;
    else if (wr_sec)
      sixty_tick_count <= reg_wdata & MASK_SEC;
    else if (sec_step)
      sixty_tick_count <= sec_next;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      minutes_count <= RST_TIME;
    else if (wr_min)
      minutes_count <= reg_wdata & MASK_MIN;
    else if (min_step)
      minutes_count <= min_next;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      hours_count <= RST_TIME;
    else if (wr_hour)
      hours_count <= reg_wdata & MASK_HOUR;
    else if (hour_step)
      hours_count <= hour_next;
  end

  // weekday rotation, a bad pattern just shifts as written
  always_ff @(posedge clk)
  begin
    if (!rstn)
      weekday_onehot <= WEEK_FIRST;
    else if (wr_week)
      weekday_onehot <= reg_wdata[6:0];
    else if (day_step)
      weekday_onehot <= {weekday_onehot[5:0], weekday_onehot[6]};
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      date_of_month <= RST_DAY;
    else if (wr_date)
      date_of_month <= reg_wdata & MASK_DATE;
    else if (day_step)
      date_of_month <= date_next;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      month_count <= RST_DAY;
    else if (wr_month)
      month_count <= reg_wdata & MASK_MONTH;
    else if (month_step)
      month_count <= month_next;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      year_count <= RST_YEAR;
    else if (wr_year)
      year_count <= reg_wdata;
    else if (year_step)
      year_count <= year_next;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      scratch_byte <= RST_TIME;
    else if (wr_ram)
      scratch_byte <= reg_wdata;
  end

  // extension register; release clear wins so a stray test bit never sticks
  // test bit clear
  always_ff @(posedge clk)
  begin
    if (!rstn)
      extension_config <= RST_EXT;
    else
    begin
      if (wr_ext)
        extension_config <= reg_wdata & MASK_EXT;
      if (bus_release)
        extension_config[EXT_TEST] <= 1'b0;
    end
  end

  // configuration fields
  assign alarm_target_select   = extension_config[EXT_ALARM];
  assign update_period_select  = extension_config[EXT_UPD];
  assign timer_run             = extension_config[EXT_RUN];
  assign timer_source_sel_low  = extension_config[EXT_SRC_L];
  assign timer_source_sel_high = extension_config[EXT_SRC_H];

  // timer source selection; only the fast source survives a halt
  // source select
  wire [1:0] src_code  = {timer_source_sel_high, timer_source_sel_low};
  wire       src_pulse = (src_code == CCLK_SRC_4096) ? fast_tick
                       : (src_code == CCLK_SRC_64)   ? hz64_tick
                       : (src_code == CCLK_SRC_SEC)  ? sec_step
                       : min_step;
  wire       upd_pulse = update_period_select ? min_step : sec_step;
  wire [7:0] alarm_sel = alarm_target_select ? date_of_month : {1'b0, weekday_onehot};

  // registered event pulses and alarm operand
  // timer start and stop
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      timer_start         <= 1'b0;
      timer_tick          <= 1'b0;
      update_event        <= 1'b0;
      alarm_compare_value <= RST_TIME;
    end
    else
    begin
      timer_start         <= wr_ext && reg_wdata[EXT_RUN];
      timer_tick          <= timer_run && src_pulse;
      update_event        <= upd_pulse;
      alarm_compare_value <= alarm_sel;
    end
  end

  // read selection, unmapped offsets read zero
  wire [7:0] rd_mux = (reg_addr == ADDR_SEC)   ? sixty_tick_count
                    : (reg_addr == ADDR_MIN)   ? minutes_count
                    : (reg_addr == ADDR_HOUR)  ? hours_count
                    : (reg_addr == ADDR_WEEK)  ? {1'b0, weekday_onehot}
                    : (reg_addr == ADDR_DATE)  ? date_of_month
                    : (reg_addr == ADDR_MONTH) ? month_count
                    : (reg_addr == ADDR_YEAR)  ? year_count
                    : (reg_addr == ADDR_RAM)   ? scratch_byte
                    : (reg_addr == ADDR_EXT)   ? extension_config
                    : 8'h00;

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rstn || !reg_rd)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= rd_mux;
  end

  // checks on counter behaviour
  a_sec_wrap:
    assert property (@(posedge clk) disable iff (!rstn)
      sec_tick && !reg_wr && (sixty_tick_count == BCD_MAX_MS)
      |=> (sixty_tick_count == BCD_ZERO))
    else $error("seconds did not wrap to 00");

  a_min_carry:
    assert property (@(posedge clk) disable iff (!rstn)
      sec_tick && !reg_wr && (sixty_tick_count == BCD_MAX_MS)
      |=> $changed(minutes_count))
    else $error("seconds rollover did not carry into minutes");

  a_hour_wrap:
    assert property (@(posedge clk) disable iff (!rstn)
      hour_step && !reg_wr && (hours_count == BCD_MAX_HR)
      |=> (hours_count == BCD_ZERO) && $changed(weekday_onehot))
    else $error("hours did not wrap with a weekday step");

  a_week_rotate:
    assert property (@(posedge clk) disable iff (!rstn)
      day_step && !reg_wr && (weekday_onehot == WEEK_LAST)
      |=> (weekday_onehot == WEEK_FIRST))
    else $error("weekday did not return to sunday");

  a_leap_feb:
    assert property (@(posedge clk) disable iff (!rstn)
      day_step && !reg_wr && (month_count == BCD_FEB)
      && (date_of_month == BCD_D28) && (year_count == 8'h04)
      |=> (date_of_month == BCD_D29) && (month_count == BCD_FEB))
    else $error("leap february skipped the 29th");

  a_year_end:
    assert property (@(posedge clk) disable iff (!rstn)
      day_step && !reg_wr && (month_count == BCD_MAX_MO)
      && (date_of_month == BCD_D31)
      |=> (month_count == BCD_ONE) && (date_of_month == BCD_ONE)
      && $changed(year_count))
    else $error("new year did not roll month and year");

  a_halt_freeze:
    assert property (@(posedge clk) disable iff (!rstn)
      halt_count && !reg_wr
      |=> $stable(sixty_tick_count) && $stable(minutes_count))
    else $error("time moved while halted");

  a_test_clear:
    assert property (@(posedge clk) disable iff (!rstn)
      bus_release |=> !extension_config[EXT_TEST])
    else $error("test bit survived a bus release");

  a_ext_reserved:
    assert property (@(posedge clk) disable iff (!rstn)
      reg_rd && (reg_addr == ADDR_EXT)
      |=> (reg_rdata[3:2] == 2'h0))
    else $error("extension reserved bits read nonzero");

  a_scratch_keep:
    assert property (@(posedge clk) disable iff (!rstn)
      wr_ram ##1 !reg_wr ##1 (reg_rd && (reg_addr == ADDR_RAM) && !reg_wr)
      |=> (reg_rdata == $past(reg_wdata, 3)))
    else $error("scratch byte lost its value");

  a_update_sel:
    assert property (@(posedge clk) disable iff (!rstn)
      sec_step && !sec_top && update_period_select && !reg_wr
      |=> !update_event)
    else $error("update event fired on second while minute selected");

  a_timer_gate:
    assert property (@(posedge clk) disable iff (!rstn)
      !timer_run |=> !timer_tick)
    else $error("timer tick while timer stopped");
endmodule : cclk_core
`default_nettype wire

// File: dv/cclk_host.sv
// host model that drives the register port and reports bus stops
`timescale 1ns/1ps
`default_nettype none
module cclk_host
  import cclk_pkg::*;
(
  // clock
  input  wire logic       clk,
  // register port
  output var  logic [3:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  // bus events
  output var  logic       bus_release
);
  // idle lines at time zero
  initial
  begin
    reg_addr    = 4'h0;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    bus_release = 1'b0;
  end

  // one write cycle; released lines flip so stale values never look valid
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= (a == ADDR_EXT) ? (d & 8'h7f) : d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  // one read cycle; data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask : rd

  // stop condition seen by the serial front end
  task automatic stop_seen();
    @(posedge clk);
    bus_release <= 1'b1;
    @(posedge clk);
    bus_release <= 1'b0;
  endtask : stop_seen
endmodule : cclk_host
`default_nettype wire

// File: dv/cclk_tb.sv
// self-checking bench for the calendar clock counters
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cclk_pkg::*;
;
  localparam int FDIV    = 2;
  localparam int SEC_CYC = FDIV * 4096;
  // stimulus, design outputs and bookkeeping
  logic       clk        = 1'b0;
  logic       rstn       = 1'b0;
  logic       halt_count = 1'b0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       bus_release;
  logic       alarm_target_select;
  logic       update_period_select;
  logic       timer_run;
  logic       timer_source_sel_low;
  logic       timer_source_sel_high;
  logic [7:0] alarm_compare_value;
  logic       timer_start;
  logic       timer_tick;
  logic       update_event;
  logic [7:0] cfg_bits;
  logic [7:0] rv;
  logic [7:0] v;
  logic [7:0] mw [8] = '{8'hd9, 8'hd9, 8'he3, 8'h81, 8'hd1, 8'hf2, 8'h99, 8'h7f};
  logic [7:0] mx [8] = '{8'h59, 8'h59, 8'h23, 8'h01, 8'h11, 8'h12, 8'h99, 8'h73};
  int         cs [5][4] = '{'{6, 31, 12, 99}, '{2, 30, 9, 50}, '{3, 28, 2, 1},
                            '{4, 28, 2, 4}, '{5, 29, 2, 96}};
  int         err_total = 0;
  int         tests_run = 0;
  int         upd_cnt   = 0;
  int         start_cnt = 0;
  int         tick_cnt  = 0;
  int         seed      = 39;
  int         n;
  int         t0;
  // reference calendar in plain integers, weekday as an index
  int         s, m, h, w, d, mo, y;

  assign cfg_bits = {3'h0, alarm_target_select, update_period_select, timer_run,
                     timer_source_sel_high, timer_source_sel_low};

  // 100 MHz clock
  always #5 clk = ~clk;

  // count event pulses; they last one cycle so a level test would miss them
  always @(posedge clk)
  begin
    upd_cnt   <= upd_cnt + int'(update_event === 1'b1);
    start_cnt <= start_cnt + int'(timer_start === 1'b1);
    tick_cnt  <= tick_cnt + int'(timer_tick === 1'b1);
  end

  // short divider so a second is 8192 cycles
  cclk_core #(.FAST_DIV(FDIV)) DUT (
    .clk                   (clk),
    .rstn                  (rstn),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_rdata             (reg_rdata),
    .bus_release           (bus_release),
    .halt_count            (halt_count),
    .alarm_target_select   (alarm_target_select),
    .update_period_select  (update_period_select),
    .timer_run             (timer_run),
    .timer_source_sel_low  (timer_source_sel_low),
    .timer_source_sel_high (timer_source_sel_high),
    .alarm_compare_value   (alarm_compare_value),
    .timer_start           (timer_start),
    .timer_tick            (timer_tick),
    .update_event          (update_event)
  );

  // host on the register port
  cclk_host host (
    .clk         (clk),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .bus_release (bus_release)
  );

  // compare helpers and verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_n(input int got, input int exp, input string what);
    tests_run++;
    if (got != exp)
    begin
      err_total++;
      $display("ERROR %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk_n

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask : done

  // bounded wait for the next update pulse
  task automatic wait_upd(input int lim, output int cyc);
    int c0;
    c0  = upd_cnt;
    cyc = 0;
    while (upd_cnt == c0 && cyc < lim)
    begin
      @(posedge clk);
      #1 cyc++;
    end
    if (upd_cnt == c0)
    begin
      err_total++;
      $display("ERROR %0t no update event", $time);
      final_report();
    end
  endtask : wait_upd

  // reference model arithmetic
  function automatic logic [7:0] bcd(input int x);
    return 8'((x / 10) * 16 + x % 10);
  endfunction : bcd

  function automatic int mdays(input int mn, input int yr);
    if (mn == 2)
      return (yr % 4 == 0) ? 29 : 28;
    return (mn == 4 || mn == 6 || mn == 9 || mn == 11) ? 30 : 31;
  endfunction : mdays

  function automatic logic [7:0] cur(input int a);
    case (a)
      0: return bcd(s);
      1: return bcd(m);
      2: return bcd(h);
      3: return 8'(1 << w);
      4: return bcd(d);
      5: return bcd(mo);
      default: return bcd(y);
    endcase
  endfunction : cur

  // one second with the full carry chain
  task automatic step();
    s = (s + 1) % 60;
    if (s == 0)
      m = (m + 1) % 60;
    if (s == 0 && m == 0)
      h = (h + 1) % 24;
    if (s == 0 && m == 0 && h == 0)
    begin
      w = (w + 1) % 7;
      d = (d == mdays(mo, y)) ? 1 : d + 1;
      if (d == 1)
        mo = mo % 12 + 1;
      if (d == 1 && mo == 1)
        y = (y + 1) % 100;
    end
  endtask : step

  task automatic load();
    for (int a = 0; a < 7; a++)
      host.wr(4'(a), cur(a));
  endtask : load

  task automatic check_all(input string what);
    for (int a = 0; a < 7; a++)
    begin
      host.rd(4'(a), rv);
      chk(rv, cur(a), what);
    end
  endtask : check_all

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 16; a++)
    begin
      host.rd(4'(a), rv);
      chk(rv, (a >= 3 && a <= 6) ? 8'h01 : 8'h00, "reset or unmapped");
    end
    done("reset");
    for (int i = 0; i < 8; i++)
    begin
      host.wr(i < 7 ? 4'(i) : ADDR_EXT, mw[i]);
      host.rd(i < 7 ? 4'(i) : ADDR_EXT, rv);
      chk(rv, mx[i], "masked bits");
    end
    done("masks");
    for (int i = 0; i < 4; i++)
    begin
      v  = {1'b0, 1'(i), 1'(i >> 1), 1'b1, 2'b00, 2'(i)};
      t0 = start_cnt;
      host.wr(ADDR_EXT, v);
      repeat (2) @(posedge clk);
      #1 chk_n(start_cnt - t0, 1, "timer start");
      chk(cfg_bits, {3'h0, v[6], v[5], v[4], v[1], v[0]}, "config");
      chk(alarm_compare_value, v[6] ? 8'h11 : 8'h01, "alarm target");
      t0 = tick_cnt;
      repeat (i == 0 ? 16 * FDIV : 4 * 64 * FDIV) @(posedge clk);
      #1 chk_n(tick_cnt - t0, i == 0 ? 16 : (i == 1 ? 4 : 0), "tick rate");
    end
    host.wr(ADDR_EXT, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk(cfg_bits, 8'h00, "timer stop");
    done("extension");
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($random(seed));
      host.wr(ADDR_RAM, v);
      host.rd(ADDR_RAM, rv);
      chk(rv, v, "scratch");
    end
    host.wr(ADDR_EXT, 8'h61);
    host.stop_seen();
    host.rd(ADDR_EXT, rv);
    chk(rv, 8'h61, "stop keeps settings");
    host.wr(ADDR_EXT, 8'h00);
    done("scratch and stop");
    wait_upd(SEC_CYC * 2, n);
    for (int c = 0; c < 5; c++)
    begin
      s  = 59;
      m  = 59;
      h  = 23;
      w  = cs[c][0];
      d  = cs[c][1];
      mo = cs[c][2];
      y  = cs[c][3];
      load();
      wait_upd(SEC_CYC + 64, n);
      step();
      check_all("day rollover");
    end
    done("calendar");
    host.wr(ADDR_EXT, 8'h20);
    s = 58;
    m = 19;
    load();
    wait_upd(SEC_CYC * 3, n);
    chk_n(int'(n > SEC_CYC), 1, "minute event spacing");
    step();
    step();
    check_all("minute update");
    host.wr(ADDR_EXT, 8'h00);
    done("minute update");
    @(posedge clk);
    halt_count <= 1'b1;
    t0 = upd_cnt;
    repeat (SEC_CYC + 512) @(posedge clk);
    #1 chk_n(upd_cnt - t0, 0, "halted events");
    check_all("halted time");
    @(posedge clk);
    halt_count <= 1'b0;
    wait_upd(SEC_CYC + 64, n);
    step();
    check_all("resumed time");
    done("halt");
    final_report();
  end
endmodule : testbench
`default_nettype wire
